// *** logic/frame_codec_pkg.sv ***
// Purpose: Shared types and constants of the daisy chain frame codec
// Assumes: Bytes arrive whole; bit order on the wire is handled outside
// Notes: CRC is kept in reflected form so bytes feed in LSB first
`default_nettype none

package frame_codec_pkg;

  // Request codes carried in header bits 6 to 4 of a command frame
  typedef enum logic [2:0] {
    REQ_SINGLE_RD = 3'h0,
    REQ_SINGLE_WR = 3'h1,
    REQ_STACK_RD = 3'h2,
    REQ_STACK_WR = 3'h3,
    REQ_BCAST_RD = 3'h4,
    REQ_BCAST_WR = 3'h5,
    REQ_BCAST_WR_REV = 3'h6,
    REQ_RSVD = 3'h7
  } req_t;

  // Command header byte, bit 7 first
  typedef struct packed {
    logic is_cmd;
    req_t req;
    logic ignored;
    logic [2:0] size;
  } cmd_hdr_t;

  // Parser and responder states, Gray along the usual path
  typedef enum logic [3:0] {
    S_HDR = 4'h0,
    S_DEV = 4'h1,
    S_RA_HI = 4'h3,
    S_RA_LO = 4'h2,
    S_DATA = 4'h6,
    S_CRC_LO = 4'h7,
    S_CRC_HI = 4'h5,
    S_WR_SET = 4'h4,
    S_WR_STB = 4'hC,
    S_TX_LOAD = 4'hD,
    S_TX_FETCH = 4'hF,
    S_TX_SEND = 4'hE
  } state_t;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  localparam logic [1:0] DEV_PAD = 2'h0;
  localparam logic [7:0] INVALID_READ_VALUE = 8'h00;
  localparam logic [6:0] BUF_WORDS = 7'h08;
  localparam logic [7:0] TX_HDR_IDX = 8'h00;
  localparam logic [7:0] TX_DEV_IDX = 8'h01;
  localparam logic [7:0] TX_RA_HI_IDX = 8'h02;
  localparam logic [7:0] TX_RA_LO_IDX = 8'h03;
  localparam logic [7:0] TX_DATA_IDX = 8'h04;
  localparam logic [7:0] TX_CRC_BYTES = 8'h02;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;

  // One byte through the CRC, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

endpackage : frame_codec_pkg

`default_nettype wire

// *** logic/daisy_chain_frame_codec.sv ***
// Purpose: Receive, check, relay and execute command frames; send responses
// Assumes: Register side answers reg_addr_ok and reg_rdata from reg_addr alone
// Notes: Whole frame is held until its CRC is known, then executed
//
// Behaviour
// - Header bit 7 one marks command, zero marks response.
// - Header bits 6..4 pick single, stack, broadcast read or write, reserved.
// - Reserved request does nothing and sets the receiving link's flag.
// - Header bit 3 of a command is ignored.
// - Command header bits 2..0 give data byte count minus one.
// - Response header bits 6..0 give data byte count minus one.
// - Of commands, only single read and write carry the device address byte.
// - Every response carries a device address byte after the header.
// - Single commands answered only when address matches current direction's address.
// - Every matching device answers, even duplicates.
// - Address byte bits 7..6 zero, bits 5..0 the device address.
// - Register address is two bytes, high byte first.
// - Writes to invalid register addresses are dropped.
// - Reads of invalid register addresses return zero.
// - Mixed blocks treat each address on its own.
// - Read command data byte is byte count minus one.
// - Writes store from start address; responses return from it.
// - CRC-16 with polynomial x16+x15+x2+1, init all ones, two trailing bytes.
// - CRC over whole frame with its CRC gives zero when good.
// - CRC checked first; failing frame dropped, never executed.
// - CRC failure flags only the CRC error.
// - Failing frames are still relayed along the chain.
// - Header goes first and sets how many bytes follow.
// - Fields: header, optional address, register address, data, CRC.
// - Bytes go LSB first; CRC follows that bit-stream order.
// - Stack commands acted on only when stack member flag set.
`timescale 1ns/1ps
`default_nettype none

// Byte FIFO in front of the parser; ready is registered
module byte_fifo #(
  parameter int WIDTH = frame_codec_pkg::BYTE_W,
  parameter int DEPTH = frame_codec_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // Pointers wrap naturally only for a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Occupancy
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers, count and registered ready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW + 1)'(DEPTH));
    end
  end

  // Storage carries no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : byte_fifo

module daisy_chain_frame_codec #(
  parameter int FIFO_DEPTH = frame_codec_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  input wire logic in_from_upper,
  input wire logic dir_sel,
  input wire logic [5:0] forward_direction_address,
  input wire logic [5:0] reverse_direction_address,
  input wire logic stack_member_flag,
  input wire logic flag_clear,
  output logic relay_valid,
  output logic [7:0] relay_data,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_addr_ok,
  output logic crc_error_flag,
  output logic [1:0] reserved_request_error_flag
);
  frame_codec_pkg::state_t state;
  frame_codec_pkg::cmd_hdr_t hdr;
  logic [7:0] dev_byte;
  logic [15:0] rx_ra;
  logic [7:0] data_buf [8];
  logic [6:0] cnt;
  logic [6:0] len;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [7:0] tx_idx;
  logic [7:0] tx_last;
  logic [7:0] tx_sel;
  logic [2:0] wi;
  logic [6:0] rd_len;
  logic [5:0] my_addr;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic receiving;
  logic pop;
  logic crc_ok;
  logic selected;
  logic good_end;
  logic bad_end;
  logic rsvd_evt;

  // Single and unaddressed reads and writes
  function automatic logic is_write(input frame_codec_pkg::req_t r);
    return r == frame_codec_pkg::REQ_SINGLE_WR || r == frame_codec_pkg::REQ_STACK_WR ||
           r == frame_codec_pkg::REQ_BCAST_WR || r == frame_codec_pkg::REQ_BCAST_WR_REV;
  endfunction : is_write

  function automatic logic is_single(input frame_codec_pkg::req_t r);
    return r == frame_codec_pkg::REQ_SINGLE_RD || r == frame_codec_pkg::REQ_SINGLE_WR;
  endfunction : is_single

  byte_fifo #(.WIDTH(frame_codec_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(receiving)
  );

  // Bytes are taken only while parsing, so a long reply stalls the link
  assign receiving = (state == frame_codec_pkg::S_HDR) || (state == frame_codec_pkg::S_DEV) ||
                     (state == frame_codec_pkg::S_RA_HI) || (state == frame_codec_pkg::S_RA_LO) ||
                     (state == frame_codec_pkg::S_DATA) || (state == frame_codec_pkg::S_CRC_LO) ||
                     (state == frame_codec_pkg::S_CRC_HI);
  assign pop = receiving && fifo_valid;
  assign my_addr = dir_sel ? reverse_direction_address : forward_direction_address;
  assign crc_ok = (frame_codec_pkg::crc_byte(rx_crc, fifo_data) == frame_codec_pkg::CRC_GOOD);
  assign good_end = pop && (state == frame_codec_pkg::S_CRC_HI) && crc_ok;
  assign bad_end = pop && (state == frame_codec_pkg::S_CRC_HI) && !crc_ok;
  assign rsvd_evt = good_end && hdr.is_cmd && (hdr.req == frame_codec_pkg::REQ_RSVD);
  assign rd_len = data_buf[0][6:0];
  assign tx_last = frame_codec_pkg::TX_DATA_IDX + {1'b0, rd_len} + frame_codec_pkg::TX_CRC_BYTES;

  // Who acts: every matching device answers, duplicates collide on the wire
  always_comb begin
    selected = 1'b0;
    if (is_single(hdr.req)) begin
      selected = (dev_byte == {frame_codec_pkg::DEV_PAD, my_addr});
    end else if (hdr.req == frame_codec_pkg::REQ_STACK_RD || hdr.req == frame_codec_pkg::REQ_STACK_WR) begin
      selected = stack_member_flag;
    end else if (hdr.req != frame_codec_pkg::REQ_RSVD) begin
      selected = 1'b1;
    end
  end

  // Non-data bytes of the response frame
  always_comb begin
    tx_sel = tx_crc[15:8];
    if (tx_idx == frame_codec_pkg::TX_HDR_IDX) begin
      tx_sel = {1'b0, rd_len};
    end else if (tx_idx == frame_codec_pkg::TX_DEV_IDX) begin
      tx_sel = {frame_codec_pkg::DEV_PAD, my_addr};
    end else if (tx_idx == frame_codec_pkg::TX_RA_HI_IDX) begin
      tx_sel = rx_ra[15:8];
    end else if (tx_idx == frame_codec_pkg::TX_RA_LO_IDX) begin
      tx_sel = rx_ra[7:0];
    end else if (tx_idx != tx_last) begin
      tx_sel = tx_crc[7:0];
    end
  end

  // Parser, executor and responder
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= frame_codec_pkg::S_HDR;
      hdr <= '0;
      dev_byte <= 8'h00;
      rx_ra <= 16'h0000;
      cnt <= 7'h00;
      len <= 7'h00;
      rx_crc <= frame_codec_pkg::CRC_INIT;
      tx_crc <= frame_codec_pkg::CRC_INIT;
      tx_idx <= 8'h00;
      wi <= 3'h0;
      reg_addr <= 16'h0000;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (pop) begin
        rx_crc <= frame_codec_pkg::crc_byte(rx_crc, fifo_data);
      end
      case (state)
        frame_codec_pkg::S_HDR: begin
          if (pop) begin
            hdr <= frame_codec_pkg::cmd_hdr_t'(fifo_data);
            rx_crc <= frame_codec_pkg::crc_byte(frame_codec_pkg::CRC_INIT, fifo_data);
            cnt <= 7'h00;
            dev_byte <= 8'h00;
            len <= fifo_data[7] ? {4'h0, fifo_data[2:0]} : fifo_data[6:0];
            if (!fifo_data[7] || is_single(frame_codec_pkg::req_t'(fifo_data[6:4]))) begin
              state <= frame_codec_pkg::S_DEV;
            end else begin
              state <= frame_codec_pkg::S_RA_HI;
            end
          end
        end
        frame_codec_pkg::S_DEV: begin
          if (pop) begin
            dev_byte <= fifo_data;
            state <= frame_codec_pkg::S_RA_HI;
          end
        end
        frame_codec_pkg::S_RA_HI: begin
          if (pop) begin
            rx_ra[15:8] <= fifo_data;
            state <= frame_codec_pkg::S_RA_LO;
          end
        end
        frame_codec_pkg::S_RA_LO: begin
          if (pop) begin
            rx_ra[7:0] <= fifo_data;
            state <= frame_codec_pkg::S_DATA;
          end
        end
        frame_codec_pkg::S_DATA: begin
          if (pop) begin
            cnt <= cnt + 7'h01;
            if (cnt == len) begin
              state <= frame_codec_pkg::S_CRC_LO;
            end
          end
        end
        frame_codec_pkg::S_CRC_LO: begin
          if (pop) begin
            state <= frame_codec_pkg::S_CRC_HI;
          end
        end
        frame_codec_pkg::S_CRC_HI: begin
          if (pop) begin
            state <= frame_codec_pkg::S_HDR;
            if (!crc_ok || !hdr.is_cmd || !selected) begin
              state <= frame_codec_pkg::S_HDR;
            end else if (is_write(hdr.req)) begin
              wi <= 3'h0;
              state <= frame_codec_pkg::S_WR_SET;
            end else begin
              tx_idx <= frame_codec_pkg::TX_HDR_IDX;
              tx_crc <= frame_codec_pkg::CRC_INIT;
              state <= frame_codec_pkg::S_TX_LOAD;
            end
          end
        end
        frame_codec_pkg::S_WR_SET: begin
          reg_addr <= rx_ra + {13'h0000, wi};
          reg_wdata <= data_buf[wi];
          state <= frame_codec_pkg::S_WR_STB;
        end
        frame_codec_pkg::S_WR_STB: begin
          reg_wr <= reg_addr_ok;
          wi <= wi + 3'h1;
          state <= (wi == hdr.size) ? frame_codec_pkg::S_HDR : frame_codec_pkg::S_WR_SET;
        end
        frame_codec_pkg::S_TX_LOAD: begin
          if (tx_idx >= frame_codec_pkg::TX_DATA_IDX &&
              tx_idx <= frame_codec_pkg::TX_DATA_IDX + {1'b0, rd_len}) begin
            reg_addr <= rx_ra + {8'h00, tx_idx - frame_codec_pkg::TX_DATA_IDX};
            reg_rd <= 1'b1;
            state <= frame_codec_pkg::S_TX_FETCH;
          end else begin
            out_data <= tx_sel;
            out_valid <= 1'b1;
            state <= frame_codec_pkg::S_TX_SEND;
          end
        end
        frame_codec_pkg::S_TX_FETCH: begin
          out_data <= reg_addr_ok ? reg_rdata : frame_codec_pkg::INVALID_READ_VALUE;
          out_valid <= 1'b1;
          state <= frame_codec_pkg::S_TX_SEND;
        end
        frame_codec_pkg::S_TX_SEND: begin
          if (out_ready) begin
            out_valid <= 1'b0;
            // The two CRC bytes must not feed the sum they carry
            if (tx_idx <= frame_codec_pkg::TX_DATA_IDX + {1'b0, rd_len}) begin
              tx_crc <= frame_codec_pkg::crc_byte(tx_crc, out_data);
            end
            tx_idx <= tx_idx + 8'h01;
            state <= (tx_idx == tx_last) ? frame_codec_pkg::S_HDR : frame_codec_pkg::S_TX_LOAD;
          end
        end
        default: begin
          state <= frame_codec_pkg::S_HDR;
        end
      endcase
    end
  end

  // Data bytes beyond eight belong to relayed responses and are not kept
  always_ff @(posedge core_clk) begin
    if (pop && state == frame_codec_pkg::S_DATA && cnt < frame_codec_pkg::BUF_WORDS) begin
      data_buf[cnt[2:0]] <= fifo_data;
    end
  end

  // Every byte goes on down the chain whether or not the CRC holds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_valid <= 1'b0;
      relay_data <= 8'h00;
    end else begin
      relay_valid <= pop;
      if (pop) begin
        relay_data <= fifo_data;
      end
    end
  end

  // Sticky error flags; a new event beats a simultaneous clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_error_flag <= 1'b0;
      reserved_request_error_flag <= 2'h0;
    end else begin
      if (bad_end) begin
        crc_error_flag <= 1'b1;
      end else if (flag_clear) begin
        crc_error_flag <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (rsvd_evt && (in_from_upper == i[0])) begin
          reserved_request_error_flag[i] <= 1'b1;
        end else if (flag_clear) begin
          reserved_request_error_flag[i] <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence crc_good_end;
    pop && state == frame_codec_pkg::S_CRC_HI && crc_ok && hdr.is_cmd;
  endsequence

  a_relay_echo: assert property (pop |=> relay_valid && relay_data == $past(fifo_data))
    else $error("relayed byte differs from received byte");
  a_crc_drop: assert property (bad_end |=> state == frame_codec_pkg::S_HDR && crc_error_flag
    && !reg_wr ##1 !reg_wr)
    else $error("bad frame was executed or unflagged");
  a_rsvd_flag: assert property (crc_good_end ##0 hdr.req == frame_codec_pkg::REQ_RSVD
    |=> state == frame_codec_pkg::S_HDR && reserved_request_error_flag != 2'h0)
    else $error("reserved request not flagged");
  a_wr_valid_only: assert property (reg_wr |-> $past(reg_addr_ok) && $past(state) == frame_codec_pkg::S_WR_STB)
    else $error("write strobe to invalid address");
  a_rd_zero: assert property (state == frame_codec_pkg::S_TX_FETCH && !reg_addr_ok
    |=> out_valid && out_data == frame_codec_pkg::INVALID_READ_VALUE)
    else $error("invalid read returned nonzero");
  a_resp_hdr: assert property (out_valid && tx_idx == frame_codec_pkg::TX_HDR_IDX |-> !out_data[7])
    else $error("response header marked as command");
  a_dev_byte: assert property (out_valid && tx_idx == frame_codec_pkg::TX_DEV_IDX
    |-> out_data == {frame_codec_pkg::DEV_PAD, my_addr})
    else $error("response address byte wrong");
  a_single_match: assert property (crc_good_end ##0 is_single(hdr.req) &&
    dev_byte != {frame_codec_pkg::DEV_PAD, my_addr} |=> state == frame_codec_pkg::S_HDR)
    else $error("single command served with foreign address");
  a_stack_gate: assert property (crc_good_end ##0 hdr.req == frame_codec_pkg::REQ_STACK_WR &&
    !stack_member_flag |=> state == frame_codec_pkg::S_HDR)
    else $error("stack write served by non-member");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("response byte dropped before acceptance");
endmodule : daisy_chain_frame_codec

`default_nettype wire

// *** test/chain_far_model.sv ***
// Purpose: Far side of the codec: register space and response sink
// Assumes: Register answers are combinational in reg_addr
// Notes: Invalid reads give junk so the codec must zero them itself
`timescale 1ns/1ps
`default_nettype none
module chain_far_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  output logic reg_addr_ok
);
  logic [7:0] resp [0:255];
  logic [15:0] last_addr;
  logic [7:0] last_data;
  logic [1:0] tick;
  int n_resp;
  int n_wr;
  // Only page zero is populated; the rest reads as junk
  assign reg_addr_ok = (reg_addr[15:8] == 8'h00);
  assign reg_rdata = reg_addr_ok ? (reg_addr[7:0] ^ 8'h5A) : 8'h3C;
  // Slow taker: refuses one cycle in four, or all while stalled
  assign out_ready = !stall && (tick != 2'h3);
  // Capture response bytes and register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 2'h0;
      n_resp <= 0;
      n_wr <= 0;
    end else begin
      tick <= tick + 2'h1;
      if (clr) begin
        n_resp <= 0;
        n_wr <= 0;
      end else begin
        if (out_valid && out_ready) begin
          resp[n_resp[7:0]] <= out_data;
          n_resp <= n_resp + 1;
        end
        if (reg_wr) begin
          n_wr <= n_wr + 1;
          last_addr <= reg_addr;
          last_data <= reg_wdata;
        end
      end
    end
  end
endmodule : chain_far_model
`default_nettype wire

// *** test/daisy_chain_frame_codec_bench.sv ***
// Purpose: Self-checking bench for the daisy chain frame codec
// Assumes: Device address 0x05 forward, 0x09 reverse
// Notes: Ordinary frames in a table, awkward cases after it
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_frame_codec_bench;
  typedef struct {logic [7:0] hdr; logic [7:0] dev; logic [7:0] d0; int nwr; int nresp;} row_t;
  logic core_clk, rst_n, in_valid, in_ready, in_from_upper, dir_sel, stack_member_flag, flag_clear;
  logic relay_valid, out_valid, out_ready, reg_wr, reg_rd, reg_addr_ok, crc_error_flag, clr, stall, rdy;
  logic [7:0] in_data, relay_data, out_data, reg_wdata, reg_rdata;
  logic [15:0] reg_addr;
  logic [1:0] reserved_request_error_flag;
  logic [7:0] fq[$];
  row_t rows[9];
  int n_mismatch, n_tests, n_relay, n_rd, acc;
  daisy_chain_frame_codec #(.FIFO_DEPTH(8)) u_daisy_chain_frame_codec (.core_clk(core_clk), .rst_n(rst_n),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .in_from_upper(in_from_upper),
    .dir_sel(dir_sel), .forward_direction_address(6'h05), .reverse_direction_address(6'h09),
    .stack_member_flag(stack_member_flag), .flag_clear(flag_clear), .relay_valid(relay_valid),
    .relay_data(relay_data), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_addr_ok(reg_addr_ok), .crc_error_flag(crc_error_flag),
    .reserved_request_error_flag(reserved_request_error_flag));
  chain_far_model u_chain_far_model (.core_clk(core_clk), .rst_n(rst_n), .clr(clr), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_addr_ok(reg_addr_ok));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Relayed bytes are compared and counted per frame; read strobes counted
  always @(posedge core_clk) begin
    if (relay_valid === 1'b1) begin
      chk(relay_data, fq[n_relay]);
      n_relay++;
    end
    if (reg_rd === 1'b1) n_rd++;
  end
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Own reflected CRC, bytes least significant bit first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction : crc16
  // Frame in field order; bad flips one CRC bit
  task automatic build(input logic [7:0] hdr, dev, input logic [15:0] ra, input logic [7:0] d0, input logic bad);
    logic [15:0] c;
    int n;
    fq.delete();
    fq.push_back(hdr);
    if (!hdr[7] || hdr[6:5] == 2'b00) fq.push_back(dev);
    fq.push_back(ra[15:8]);
    fq.push_back(ra[7:0]);
    n = hdr[7] ? int'(hdr[2:0]) + 1 : int'(hdr[6:0]) + 1;
    for (int i = 0; i < n; i++) fq.push_back(d0 + 8'(i));
    c = 16'hFFFF;
    foreach (fq[i]) c = crc16(c, fq[i]);
    c[0] = c[0] ^ bad;
    fq.push_back(c[7:0]);
    fq.push_back(c[15:8]);
  endtask : build
  // Hold the byte until an edge sees in_ready high
  task automatic put(input logic [7:0] b);
    int k;
    in_valid = 1'b1;
    in_data = b;
    for (k = 0; k < 1000 && in_ready !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (k == 1000) begin
      n_mismatch++;
      final_report();
    end else begin
      @(posedge core_clk);
      #1;
    end
  endtask : put
  // Wait for 40 quiet cycles, bounded
  task automatic settle();
    int q;
    int k;
    q = 0;
    for (k = 0; k < 3000 && q < 40; k++) begin
      @(posedge core_clk);
      #1;
      q = (out_valid === 1'b0 && relay_valid === 1'b0 && reg_wr === 1'b0 && reg_rd === 1'b0) ? q + 1 : 0;
    end
    if (k == 3000) begin
      n_mismatch++;
      final_report();
    end
  endtask : settle
  task automatic send(input int start);
    for (int i = start; i < fq.size(); i++) put(fq[i]);
    in_valid = 1'b0;
    // A stalled taker never goes quiet
    if (stall === 1'b0) settle();
  endtask : send
  task automatic go(input logic [7:0] hdr, dev, input logic [15:0] ra, input logic [7:0] d0, input logic bad);
    clr = 1'b1;
    @(posedge core_clk);
    #1;
    clr = 1'b0;
    n_relay = 0;
    n_rd = 0;
    build(hdr, dev, ra, d0, bad);
    send(0);
  endtask : go
  task automatic check_resp(input logic [7:0] cnt, input logic [15:0] ra, input logic [7:0] da, db);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < u_chain_far_model.n_resp; i++) c = crc16(c, u_chain_far_model.resp[i]);
    chk(c, 0);
    chk(u_chain_far_model.resp[0], {1'b0, cnt[6:0]});
    chk(u_chain_far_model.resp[1], 8'h05);
    chk({u_chain_far_model.resp[2], u_chain_far_model.resp[3]}, ra);
    chk(u_chain_far_model.resp[4], da);
    if (cnt != 8'h00) chk(u_chain_far_model.resp[5], db);
  endtask : check_resp
  // Main sequence
  initial begin
    rst_n = 1'b0; in_valid = 1'b0; in_data = 8'h00; in_from_upper = 1'b0; dir_sel = 1'b0;
    stack_member_flag = 1'b1; flag_clear = 1'b0; clr = 1'b0; stall = 1'b0;
    n_mismatch = 0; n_tests = 0; n_relay = 0; n_rd = 0;
    rows = '{'{8'h80, 8'h05, 8'h01, 0, 8}, '{8'h80, 8'h06, 8'h00, 0, 0}, '{8'h91, 8'h05, 8'h33, 2, 0},
      '{8'hB0, 8'h00, 8'h44, 1, 0}, '{8'hD8, 8'h00, 8'h55, 1, 0}, '{8'hE0, 8'h00, 8'h66, 1, 0},
      '{8'hC0, 8'h00, 8'h00, 0, 7}, '{8'hA0, 8'h00, 8'h02, 0, 9}, '{8'h01, 8'h07, 8'h00, 0, 0}};
    repeat (4) @(posedge core_clk);
    #1;
    chk({out_valid, relay_valid, reg_wr, crc_error_flag, reserved_request_error_flag}, 0);
    rst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    foreach (rows[r]) begin
      go(rows[r].hdr, rows[r].dev, 16'h0010, rows[r].d0, 1'b0);
      chk(n_relay, fq.size());
      chk(u_chain_far_model.n_wr, rows[r].nwr);
      chk(u_chain_far_model.n_resp, rows[r].nresp);
      if (rows[r].nwr > 0) chk(u_chain_far_model.last_data, rows[r].d0 + 8'(rows[r].nwr - 1));
      chk(n_rd, (rows[r].nresp > 0) ? rows[r].nresp - 6 : 0);
      if (rows[r].nresp > 0) check_resp(rows[r].d0, 16'h0010, 8'h4A, 8'h4B);
    end
    // Stack write ignored when not a stack member
    stack_member_flag = 1'b0;
    go(8'hB0, 8'h00, 16'h0010, 8'h44, 1'b0);
    chk(u_chain_far_model.n_wr, 0);
    stack_member_flag = 1'b1;
    // Reverse direction uses the other address
    dir_sel = 1'b1;
    go(8'h90, 8'h09, 16'h0020, 8'h77, 1'b0);
    chk(u_chain_far_model.n_wr, 1);
    go(8'h90, 8'h05, 16'h0020, 8'h77, 1'b0);
    chk(u_chain_far_model.n_wr, 0);
    dir_sel = 1'b0;
    // Blocks straddling the end of the valid page
    go(8'h91, 8'h05, 16'h00FF, 8'h21, 1'b0);
    chk(u_chain_far_model.n_wr, 1);
    chk(u_chain_far_model.last_addr, 16'h00FF);
    go(8'h80, 8'h05, 16'h00FF, 8'h01, 1'b0);
    check_resp(8'h01, 16'h00FF, 8'hA5, 8'h00);
    // Bad CRC on a reserved request: relayed, only CRC flagged
    go(8'hF0, 8'h00, 16'h0010, 8'h00, 1'b1);
    chk(n_relay, fq.size());
    chk({crc_error_flag, reserved_request_error_flag}, 3'b100);
    go(8'h90, 8'h05, 16'h0010, 8'h12, 1'b1);
    chk(u_chain_far_model.n_wr, 0);
    flag_clear = 1'b1;
    @(posedge core_clk);
    #1;
    flag_clear = 1'b0;
    chk(crc_error_flag, 0);
    // Reserved request flags the receiving link only
    in_from_upper = 1'b1;
    go(8'hF0, 8'h00, 16'h0010, 8'h00, 1'b0);
    chk({u_chain_far_model.n_wr[0], reserved_request_error_flag}, 3'b010);
    in_from_upper = 1'b0;
    go(8'hF0, 8'h00, 16'h0010, 8'h00, 1'b0);
    chk(reserved_request_error_flag, 2'b11);
    // Long read stalled by the far side; FIFO fills and refuses
    stall = 1'b1;
    go(8'hC0, 8'h00, 16'h0010, 8'h7F, 1'b0);
    repeat (4) @(posedge core_clk);
    #1;
    chk(out_valid, 1);
    build(8'hD7, 8'h00, 16'h0010, 8'h80, 1'b0);
    n_relay = 0;
    in_valid = 1'b1;
    acc = 0;
    repeat (20) begin
      in_data = fq[acc];
      rdy = in_ready;
      @(posedge core_clk);
      #1;
      if (rdy === 1'b1) acc++;
    end
    chk(acc, 8);
    stall = 1'b0;
    send(acc);
    chk(u_chain_far_model.n_resp, 134);
    check_resp(8'h7F, 16'h0010, 8'h4A, 8'h4B);
    chk(u_chain_far_model.n_wr, 8);
    chk(u_chain_far_model.last_addr, 16'h0017);
    final_report();
  end
endmodule : daisy_chain_frame_codec_bench
`default_nettype wire
